/* File: hdl/pmuseq_regs.vh */
/*
 * constants for the rail sequencer: register offsets, bit positions,
 * timing figures and the cycle counts derived from them.
 * assumes a 50 mhz sequencer clock.
 */
`ifndef PMUSEQ_REGS_VH
`define PMUSEQ_REGS_VH

`define PMUSEQ_ADDR_TIMED_CYCLE   8'hc0
`define PMUSEQ_ADDR_CYCLE_TRIG    8'hc3
`define PMUSEQ_ADDR_MANUAL_RESET  8'hd3
`define PMUSEQ_ADDR_SHUTDOWN      8'hc1
`define PMUSEQ_ADDR_RAIL_ENABLE   8'hc2
`define PMUSEQ_ADDR_STATUS        8'hc4
`define PMUSEQ_BIT_CTRL           0
`define PMUSEQ_CLK_MHZ            50
`define PMUSEQ_START_DELAY_US     2000
`define PMUSEQ_RESET_DELAY_MS     40
`define PMUSEQ_CYCLE_DELAY_MS     8
`define PMUSEQ_TIMED_DELAY_S      4
`define PMUSEQ_OFF_TIME_MS        8
`define PMUSEQ_START_CYC  (`PMUSEQ_START_DELAY_US * `PMUSEQ_CLK_MHZ)
`define PMUSEQ_RESET_CYC  (`PMUSEQ_RESET_DELAY_MS * 1000 * `PMUSEQ_CLK_MHZ)
`define PMUSEQ_CYCLE_CYC  (`PMUSEQ_CYCLE_DELAY_MS * 1000 * `PMUSEQ_CLK_MHZ)
`define PMUSEQ_TIMED_CYC  (`PMUSEQ_TIMED_DELAY_S * 1000000 * `PMUSEQ_CLK_MHZ)
`define PMUSEQ_OFF_CYC    (`PMUSEQ_OFF_TIME_MS * 1000 * `PMUSEQ_CLK_MHZ)

`endif

/* File: hdl/pmuseq_top.v */
/*
 * sequencing and reset logic of a thirteen-rail power unit: rail enables,
 * processor reset output and two register-started power-cycle procedures.
 * assumes a register port from an i2c slave outside (address, data,
 * one-cycle write strobe, combinational read) and a power-good per rail.
 */
`include "pmuseq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pmuseq_top #(
    parameter integer START_CYC = `PMUSEQ_START_CYC,
    parameter integer RESET_CYC = `PMUSEQ_RESET_CYC,
    parameter integer CYCLE_CYC = `PMUSEQ_CYCLE_CYC,
    parameter integer TIMED_CYC = `PMUSEQ_TIMED_CYC,
    parameter integer OFF_CYC   = `PMUSEQ_OFF_CYC
) (
    input  wire        clk,
    input  wire        nrst,
    input  wire        input_power_valid,
    input  wire [12:0] rail_good,
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg  [12:0] rail_enable,
    output reg         reset_out_n,
    output reg         watchdog_enable,
    output reg         dynamic_voltage_switch
);

    // one-hot top-level power states
    localparam [3:0] ST_OFF = 4'b0001;
    localparam [3:0] ST_ON  = 4'b0010;
    localparam [3:0] ST_DN  = 4'b0100;
    localparam [3:0] ST_SHUT = 4'b1000;

    // trigger source of each rail, index into {input_power_valid,rail_good}; 14 = register bit only
    // rails 1..13 map to bits 0..12; source 13 is input power valid
    function [3:0] trig_src;
        input integer r;
        begin
            case (r)
                0:  trig_src = 4'd11;  // rail one after rail twelve
                1:  trig_src = 4'd13;  // rail two on input power
                2:  trig_src = 4'd3;   // rail three after rail four
                3:  trig_src = 4'd9;   // rail four after rail ten
                4:  trig_src = 4'd14;  // rail five by register only
                5, 6, 7, 8, 9: trig_src = 4'd1;
                10: trig_src = 4'd13;
                11: trig_src = 4'd3;
                default: trig_src = 4'd14; // rail thirteen register only
            endcase
        end
    endfunction

    // decode of the register address, shared by write and read paths
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    reg  [3:0]  state;
    reg         timed_power_cycle_enable;
    reg         manual_reset_bit;
    reg         power_cycle_trigger_bit;
    reg  [1:0]  manual_rail_en;      // rail five, rail thirteen
    reg  [31:0] mr_cnt;
    reg         mr_armed;
    reg  [31:0] pc_cnt;
    reg         pc_armed;
    reg  [31:0] timed_cnt;
    reg  [31:0] rst_cnt;
    reg  [31:0] off_cnt;
    reg         mr_hold;
    wire [13:0] src_up = {input_power_valid, rail_good};
    wire        seq_run = (state == ST_ON);
    wire        wr_mr = reg_wr && hit(reg_addr, `PMUSEQ_ADDR_MANUAL_RESET);
    wire        wr_pc = reg_wr && hit(reg_addr, `PMUSEQ_ADDR_CYCLE_TRIG);
    wire        wr_tm = reg_wr && hit(reg_addr, `PMUSEQ_ADDR_TIMED_CYCLE);
    wire        mr_set = wr_mr && reg_wdata[`PMUSEQ_BIT_CTRL];
    wire        pc_set = wr_pc && reg_wdata[`PMUSEQ_BIT_CTRL];
    wire        pc_fire = pc_armed && (pc_cnt == CYCLE_CYC - 1);
    wire        tm_fire = timed_power_cycle_enable
                          && (timed_cnt == TIMED_CYC - 1);
    wire        shut_req = reg_wr && hit(reg_addr, `PMUSEQ_ADDR_SHUTDOWN)
                           && reg_wdata[`PMUSEQ_BIT_CTRL];

    // per-rail delay counters; register-only rails follow their bit
    genvar g;
    generate
        for (g = 0; g < 13; g = g + 1)
        begin : g_rail
            reg [31:0] dly;
            // rail five sits on bit 0 of the enable register, thirteen on 1
            wire       man_on = (g == 4) ? manual_rail_en[0]
                                         : manual_rail_en[1];
            wire       up = (trig_src(g) == 4'd14) ? man_on
                            : src_up[trig_src(g)];
            always @(posedge clk)
            begin
                if (!nrst || !seq_run || !up)
                begin
                    dly            <= 32'h0000_0000;
                    rail_enable[g] <= 1'b0;
                end
                else if (trig_src(g) >= 4'd13)
                    rail_enable[g] <= 1'b1;
                else if (dly == START_CYC - 1)
                    rail_enable[g] <= 1'b1;
                else
                    dly <= dly + 32'h0000_0001;
            end
        end
    endgenerate

    // read mux, combinational; unmapped addresses read zero
    always @*
    begin
        reg_rdata = 8'h00;
        if (hit(reg_addr, `PMUSEQ_ADDR_TIMED_CYCLE))
            reg_rdata = {7'h00, timed_power_cycle_enable};
        else if (hit(reg_addr, `PMUSEQ_ADDR_CYCLE_TRIG))
            reg_rdata = {7'h00, power_cycle_trigger_bit};
        else if (hit(reg_addr, `PMUSEQ_ADDR_MANUAL_RESET))
            reg_rdata = {7'h00, manual_reset_bit};
        else if (hit(reg_addr, `PMUSEQ_ADDR_RAIL_ENABLE))
            reg_rdata = {6'h00, manual_rail_en};
        else if (hit(reg_addr, `PMUSEQ_ADDR_STATUS))
            reg_rdata = {4'h0, state};
    end

    // control registers and power-cycle timers
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            timed_power_cycle_enable <= 1'b0;
            manual_reset_bit         <= 1'b0;
            power_cycle_trigger_bit  <= 1'b0;
            manual_rail_en           <= 2'b00;
            mr_cnt    <= 32'h0000_0000;
            mr_armed  <= 1'b0;
            pc_cnt    <= 32'h0000_0000;
            pc_armed  <= 1'b0;
            timed_cnt <= 32'h0000_0000;
            mr_hold   <= 1'b0;
            watchdog_enable        <= 1'b0;
            dynamic_voltage_switch <= 1'b0;
        end
        else
        begin
            if (wr_tm)
                timed_power_cycle_enable <= reg_wdata[0];
            if (reg_wr && hit(reg_addr, `PMUSEQ_ADDR_RAIL_ENABLE))
                manual_rail_en <= reg_wdata[1:0];
            if (wr_mr)
                manual_reset_bit <= reg_wdata[0];
            if (wr_pc)
                power_cycle_trigger_bit <= reg_wdata[0];
            // timed cycle counts while enabled; the bit itself survives
            if (timed_power_cycle_enable && !tm_fire)
                timed_cnt <= timed_cnt + 32'h0000_0001;
            else
                timed_cnt <= 32'h0000_0000;
            // manual-reset window: trigger must land within it
            if (mr_set)
            begin
                mr_armed <= 1'b1;
                mr_cnt   <= 32'h0000_0000;
            end
            else if (mr_armed && mr_cnt == CYCLE_CYC - 1)
            begin
                mr_armed <= 1'b0;
                // a trigger landing on the last window cycle still counts
                mr_hold  <= pc_armed || pc_set;
                if (!pc_armed && !pc_set)
                    manual_reset_bit <= 1'b0;
            end
            else if (mr_armed)
                mr_cnt <= mr_cnt + 32'h0000_0001;
            if (pc_set && mr_armed)
            begin
                pc_armed <= 1'b1;
                pc_cnt   <= 32'h0000_0000;
            end
            else if (pc_fire)
            begin
                pc_armed <= 1'b0;
                mr_hold  <= 1'b0;
                // a host write in the same cycle wins over the clear
                if (!mr_set)
                    manual_reset_bit <= 1'b0;
                if (!pc_set)
                    power_cycle_trigger_bit <= 1'b0;
            end
            else if (pc_armed)
                pc_cnt <= pc_cnt + 32'h0000_0001;
        end
    end

    // power state machine
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state   <= ST_OFF;
            off_cnt <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                ST_OFF:
                    if (input_power_valid)
                        state <= ST_ON;
                ST_ON:
                    if (!input_power_valid)
                        state <= ST_OFF;
                    else if (shut_req)
                        state <= ST_SHUT;
                    else if (pc_fire || tm_fire)
                    begin
                        state   <= ST_DN;
                        off_cnt <= 32'h0000_0000;
                    end
                ST_DN:
                    // rails held off briefly, then restart
                    if (off_cnt == OFF_CYC - 1)
                        state <= ST_OFF;
                    else
                        off_cnt <= off_cnt + 32'h0000_0001;
                ST_SHUT:
                    // stays off until input power is lost
                    if (!input_power_valid)
                        state <= ST_OFF;
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // reset output: 40 ms after rail four good, forced low when a manual-reset window that caught a trigger closes
    always @(posedge clk)
    begin
        if (!nrst || !seq_run || !rail_good[3] || mr_hold)
        begin
            rst_cnt     <= 32'h0000_0000;
            reset_out_n <= 1'b0;
        end
        else if (rst_cnt == RESET_CYC - 1)
            reset_out_n <= 1'b1;
        else
            rst_cnt <= rst_cnt + 32'h0000_0001;
    end

endmodule // pmuseq_top
`default_nettype wire

/* File: testbench/pmuseq_rails.sv */
/* rail model: each power-good follows its enable after a short ramp.
   assumes rail_enable from pmuseq_top, one clock. */
`timescale 1ns/1ps
`default_nettype none
module pmuseq_rails (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [12:0] rail_enable,
    output var  logic [12:0] rail_good
);
    logic [12:0] en_d1 = 13'h0;
    logic [12:0] en_d2 = 13'h0;
    initial rail_good = 13'h0;
    // good only after the ramp; slow mode stretches it by one edge
    always @(posedge clk)
    begin
        en_d1     <= rail_enable;
        en_d2     <= en_d1 & rail_enable;
        rail_good <= en_d1 & rail_enable & (slow ? en_d2 : 13'h1fff);
    end
endmodule // pmuseq_rails
`default_nettype wire

/* File: testbench/pmuseq_assertions.sv */
/* port checker for pmuseq_top.
   assumes one clock and the shortened counts of the bench. */
`timescale 1ns/1ps
`default_nettype none
module pmuseq_chk #(
    parameter integer START_CYC = 20,
    parameter integer RESET_CYC = 30,
    parameter integer CYCLE_CYC = 40,
    parameter integer TIMED_CYC = 100
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        input_power_valid,
    input wire logic [12:0] rail_good,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [12:0] rail_enable,
    input wire logic        reset_out_n,
    input wire logic        watchdog_enable,
    input wire logic        dynamic_voltage_switch
);
    localparam int CL = CYCLE_CYC - 2;
    localparam int CH = CYCLE_CYC + 2;
    localparam int TL = TIMED_CYC - 10;
    localparam int TH = TIMED_CYC + 3;
    logic [7:0] gcnt;
    logic [7:0] rcnt;
    wire logic  wd3 = reg_wr && reg_addr == 8'hd3 && reg_wdata[0];
    wire logic  wc3 = reg_wr && reg_addr == 8'hc3 && reg_wdata[0];
    wire logic  wc1 = reg_wr && reg_addr == 8'hc1 && reg_wdata[0];
    wire logic  wc0 = reg_wr && reg_addr == 8'hc0 && reg_wdata[0];
    // run lengths of trigger good; an early enable shows a short run
    always_ff @(posedge clk)
    begin
        gcnt <= (!nrst || !rail_good[1]) ? 8'h00 : gcnt + {7'h0, ~&gcnt};
        rcnt <= (!nrst || !rail_good[3]) ? 8'h00 : rcnt + {7'h0, ~&rcnt};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_arm;
        wd3 ##[1:CL] wc3;
    endsequence
    property p_wdog; !watchdog_enable; endproperty
    property p_dvs; !dynamic_voltage_switch; endproperty
    property p_chain; $rose(rail_enable[5]) |-> gcnt == START_CYC;
    endproperty
    property p_input_power_valid; $rose(rail_enable[1]) |->
        rail_enable[10] && $past(input_power_valid, 2); endproperty
    property p_rst; $rose(reset_out_n) |->
        rail_good[3] && rcnt >= RESET_CYC; endproperty
    property p_shut; wc1 |-> ##[1:3] rail_enable == 13'h0; endproperty
    property p_pc; s_arm |-> ##[CL:CH] !reset_out_n && rail_enable == 13'h0;
    endproperty
    property p_tmd; wc0 |-> ##[TL:TH] rail_enable == 13'h0; endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog enabled");
    a_dvs: assert property (p_dvs)
        else $error("voltage switching active");
    a_chain: assert property (p_chain)
        else $error("chained rail enabled early");
    a_input_power_valid: assert property (p_input_power_valid)
        else $error("direct rails wrong at power valid");
    a_rst: assert property (p_rst)
        else $error("reset released early");
    a_shut: assert property (p_shut)
        else $error("shutdown left rails on");
    a_pc: assert property (p_pc)
        else $error("power cycle missing");
    a_tmd: assert property (p_tmd)
        else $error("timed power cycle missing");
endmodule // pmuseq_chk
`default_nettype wire

/* File: testbench/testbench.sv */
/* self-checking bench for pmuseq_top with a rail model on the
   power-good side. assumes the shortened counts set at the instance. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [12:0] ALL_ON = 13'h0fef;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        input_power_valid = 1'b0;
    logic        reg_wr = 1'b0;
    logic        slow = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [12:0] rail_good;
    logic [12:0] rail_enable;
    logic        reset_out_n;
    logic        watchdog_enable;
    logic        dynamic_voltage_switch;
    int          err_total = 0;
    int          compares = 0;
    int          n;
    pmuseq_top #(.START_CYC(20), .RESET_CYC(30), .CYCLE_CYC(40),
                 .TIMED_CYC(100), .OFF_CYC(10)) DUT (
        .clk(clk), .nrst(nrst), .input_power_valid(input_power_valid),
        .rail_good(rail_good), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rail_enable(rail_enable), .reset_out_n(reset_out_n),
        .watchdog_enable(watchdog_enable),
        .dynamic_voltage_switch(dynamic_voltage_switch));
    pmuseq_rails u_rails (.clk(clk), .slow(slow),
        .rail_enable(rail_enable), .rail_good(rail_good));
    task results;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wt(input int c);
        repeat (c) @(negedge clk);
    endtask
    // one-cycle strobe, launched and dropped on falling edges
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        #1 chk(reg_rdata, e);
    endtask
    function logic cur(input int w);
        case (w)
            0: return reset_out_n;
            1: return rail_enable == 13'h0;
            2: return rail_good[3];
            default: return rail_enable[1];
        endcase
    endfunction
    // bounded wait; a hang ends the run as a mismatch
    task wait_sig(input int w, input logic v, output int c);
        c = 0;
        while (cur(w) !== v && c < 3000)
        begin
            @(negedge clk);
            c++;
        end
        if (c >= 3000)
        begin
            err_total++;
            results();
        end
    endtask
    initial
    begin
        forever #10 clk = ~clk;
    end
    initial
    begin
        wt(5);
        chk(reset_out_n, 0);
        nrst = 1'b1;
        wt(3);
        chk(rail_enable, 0);
        input_power_valid = 1'b1;
        wt(3);
        chk(rail_enable, 13'h0402);
        wait_sig(2, 1, n);
        wait_sig(0, 1, n);
        chk(n >= 30 && n <= 33, 1);
        // rail one trails rail four good by two start delays
        wt(20);
        chk(rail_enable, ALL_ON);
        wr(8'hc2, 8'h03);
        rd(8'hc2, 8'h03);
        chk(rail_enable, 13'h1fff);
        wr(8'hc2, 8'h00);
        rd(8'hc4, 8'h02);
        chk(rail_enable, ALL_ON);
        slow = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'hc1, 8'h00);
        wr(8'hd3, 8'h01);
        wt(45);
        chk(reset_out_n, 1);
        chk(rail_enable, ALL_ON);
        rd(8'hd3, 8'h00);
        wr(8'hd3, 8'h01);
        wt(10);
        wr(8'hc3, 8'h01);
        rd(8'hc3, 8'h01);
        wait_sig(0, 0, n);
        chk(n >= 26 && n <= 31, 1);
        wait_sig(1, 1, n);
        chk(n >= 9 && n <= 15, 1);
        wait_sig(0, 1, n);
        wt(20);
        chk(rail_enable, ALL_ON);
        wr(8'hc0, 8'h01);
        rd(8'hc0, 8'h01);
        wait_sig(1, 1, n);
        chk(n >= 94 && n <= 102, 1);
        wait_sig(3, 1, n);
        wr(8'hc0, 8'h00);
        rd(8'hc0, 8'h00);
        wait_sig(0, 1, n);
        wt(120);
        chk(rail_enable, ALL_ON);
        wr(8'hc1, 8'h01);
        wait_sig(1, 1, n);
        chk(n <= 3, 1);
        wt(50);
        chk(rail_enable, 0);
        chk({watchdog_enable, dynamic_voltage_switch}, 0);
        rd(8'hc4, 8'h08);
        // losing input power leaves shutdown; regaining it restarts
        input_power_valid = 1'b0;
        wt(3);
        rd(8'hc4, 8'h01);
        input_power_valid = 1'b1;
        wait_sig(3, 1, n);
        chk(n <= 3, 1);
        results();
    end
endmodule // testbench
bind pmuseq_top pmuseq_chk #(.START_CYC(START_CYC), .RESET_CYC(RESET_CYC),
    .CYCLE_CYC(CYCLE_CYC), .TIMED_CYC(TIMED_CYC)) u_chk (.clk(clk),
    .nrst(nrst), .input_power_valid(input_power_valid),
    .rail_good(rail_good), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .rail_enable(rail_enable),
    .reset_out_n(reset_out_n), .watchdog_enable(watchdog_enable),
    .dynamic_voltage_switch(dynamic_voltage_switch));
`default_nettype wire
